// [inc/via_pkg.sv]
// Purpose: Shared constants and types of the vectored interrupt arbiter
// Assumes: One instruction cycle per sys_clk_i cycle
// Notes: Register offsets are byte addresses on the AXI4-Lite port
package via_pkg;
    // Register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_PEND = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    // Field positions
    localparam int CTRL_EN_LSB = 0;
    localparam int CTRL_GIE_BIT = 8;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_OFS_LSB = 8;
    localparam int SRC_W = 6;
    // Maskable source slots in the pending and enable words
    localparam int SRC_EXT = 0;
    localparam int SRC_T0 = 1;
    localparam int SRC_T1A = 2;
    localparam int SRC_T1B = 3;
    localparam int SRC_SER = 4;
    localparam int SRC_WAKE = 5;
    // Vector slot offsets, low byte of the table address
    localparam logic [7:0] OFS_TRAP = 8'hFE;
    localparam logic [7:0] OFS_EXT = 8'hFA;
    localparam logic [7:0] OFS_T0 = 8'hF8;
    localparam logic [7:0] OFS_T1A = 8'hF6;
    localparam logic [7:0] OFS_T1B = 8'hF4;
    localparam logic [7:0] OFS_SER = 8'hF2;
    localparam logic [7:0] OFS_WAKE = 8'hE2;
    localparam logic [7:0] OFS_DEF = 8'hE0;
    localparam logic [7:0] OFS_MIN = 8'hE0;
    localparam logic [7:0] BLOCK_LAST = 8'hFF;
    // Opcodes, vectors, reset values and timing
    localparam logic [7:0] OPC_TRAP = 8'h00;
    localparam logic [14:0] ACK_VEC = 15'h00FF;
    localparam int ACK_CYCLES = 7;
    localparam int DEF_MEM_BYTES = 4096;
    localparam logic [7:0] DEF_STACK_LIMIT = 8'h6F;
    localparam logic [SRC_W-1:0] RST_EN = 6'h00;
    localparam logic RST_GIE = 1'b0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        VIA_IDLE,
        VIA_ACK,
        VIA_DSP_HI,
        VIA_DSP_LO,
        VIA_DSP_LOAD
    } via_state_t;

    // Per-cycle strobes from the instruction sequencer
    typedef struct packed {
        logic instr_start;
        logic vector_dispatch_instruction;
        logic clr_trap;
        logic return_from_interrupt_instruction;
        logic pop;
        logic fetch;
    } via_core_t;
endpackage : via_pkg

// [hw/via_arbiter.sv]
// Purpose: Interrupt ranking, vector dispatch and trap pending logic
// Assumes: Sequencer strobes are on sys_clk_i; memory read data one cycle
// Assumes: after mem_rd_o; only one sequencer strobe per instruction
// Notes: Trap pending flag is internal only, never on the register bus
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
module via_arbiter #(
    parameter int MEM_BYTES = via_pkg::DEF_MEM_BYTES,
    parameter logic [7:0] STACK_LIMIT = via_pkg::DEF_STACK_LIMIT
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    output logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    input wire logic [7:0] s_axi_araddr_i,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    input wire logic [via_pkg::SRC_W-1:0] src_pulse_i,
    input wire via_pkg::via_core_t core_i,
    input wire logic [14:0] cur_pc_i,
    input wire logic [14:0] next_pc_i,
    input wire logic [14:0] pop_pc_i,
    input wire logic [7:0] sp_i,
    input wire logic [14:0] fetch_addr_i,
    input wire logic [7:0] fetch_data_i,
    input wire logic [7:0] mem_data_i,
    output logic mem_rd_o,
    output logic [14:0] mem_addr_o,
    output logic pc_load_o,
    output logic [14:0] pc_o,
    output logic push_o,
    output logic [14:0] push_addr_o,
    output logic busy_o
);
    // Refuse a memory size the 15-bit address space cannot hold
    if (MEM_BYTES < 1 || MEM_BYTES > 32768)
    begin : g_chk
        $error("MEM_BYTES out of range");
    end
    localparam logic [2:0] ACK_LAST = 3'(via_pkg::ACK_CYCLES - 2);
    typedef struct packed {
        via_pkg::via_state_t st;
        logic [2:0] cnt;
        logic trap;
        logic global_interrupt_enable;
        logic [via_pkg::SRC_W-1:0] en;
        logic [via_pkg::SRC_W-1:0] pend;
        logic [7:0] ofs;
        logic [6:0] vec_hi;
        logic mem_rd;
        logic [14:0] mem_addr;
        logic pc_load;
        logic [14:0] pc;
        logic push;
        logic [14:0] push_addr;
        logic busy; // Own flop so busy_o leaves no decode glitch
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } via_regs_t;
    via_regs_t s_r;
    via_regs_t s_nxt;
    logic trap_now;
    logic mask_ack;
    logic [via_pkg::SRC_W-1:0] act;
    // Fixed ranking; reserved slots have no source so never win
    function automatic logic [7:0] arb_ofs(
        input logic trap,
        input logic [via_pkg::SRC_W-1:0] a
    );
        logic [7:0] o;
        o = via_pkg::OFS_DEF;
        if (trap)
            o = via_pkg::OFS_TRAP;
        else if (a[via_pkg::SRC_EXT])
            o = via_pkg::OFS_EXT;
        else if (a[via_pkg::SRC_T0])
            o = via_pkg::OFS_T0;
        else if (a[via_pkg::SRC_T1A])
            o = via_pkg::OFS_T1A;
        else if (a[via_pkg::SRC_T1B])
            o = via_pkg::OFS_T1B;
        else if (a[via_pkg::SRC_SER])
            o = via_pkg::OFS_SER;
        else if (a[via_pkg::SRC_WAKE])
            o = via_pkg::OFS_WAKE;
        return o;
    endfunction : arb_ofs
    // Table block: dispatch block, or the next one from its last byte
    function automatic logic [6:0] tab_block(input logic [14:0] pc);
        logic [6:0] b;
        b = pc[14:8];
        if (pc[7:0] == via_pkg::BLOCK_LAST)
            b = 7'(pc[14:8] + 7'h01);
        return b;
    endfunction : tab_block
    // Active maskable sources and trap triggers seen this cycle
    always_comb
    begin
        act = s_r.en & s_r.pend;
        trap_now = (core_i.fetch
                    && (int'(fetch_addr_i) >= MEM_BYTES
                        || fetch_data_i == via_pkg::OPC_TRAP))
                   || (core_i.pop && sp_i > STACK_LIMIT);
        mask_ack = s_r.st == via_pkg::VIA_IDLE && core_i.instr_start
                   && s_r.global_interrupt_enable && !s_r.trap && (|act)
                   && !trap_now;
    end
    // Next state of sequencer, flags and bus slave
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.pc_load = 1'b0;
        s_nxt.push = 1'b0;
        s_nxt.mem_rd = 1'b0;
        // Sequencer: trap outranks dispatch and maskable acknowledge
        unique case (s_r.st)
            via_pkg::VIA_IDLE:
            begin
                if (trap_now)
                begin
                    s_nxt.push = 1'b1;
                    s_nxt.push_addr = core_i.fetch ? fetch_addr_i
                                                   : cur_pc_i;
                    s_nxt.st = via_pkg::VIA_ACK;
                    s_nxt.cnt = 3'h0;
                end
                else if (mask_ack)
                begin
                    s_nxt.global_interrupt_enable = 1'b0;
                    s_nxt.push = 1'b1;
                    s_nxt.push_addr = next_pc_i;
                    s_nxt.st = via_pkg::VIA_ACK;
                    s_nxt.cnt = 3'h0;
                end
                else if (core_i.vector_dispatch_instruction)
                begin
                    // Sampled once here, held for the rest of dispatch
                    s_nxt.ofs = arb_ofs(s_r.trap, act);
                    s_nxt.mem_addr = {tab_block(cur_pc_i),
                                      arb_ofs(s_r.trap, act)};
                    s_nxt.mem_rd = 1'b1;
                    s_nxt.st = via_pkg::VIA_DSP_HI;
                end
                else if (core_i.return_from_interrupt_instruction)
                begin
                    s_nxt.global_interrupt_enable = 1'b1;
                    s_nxt.pc_load = 1'b1;
                    s_nxt.pc = pop_pc_i;
                end
            end
            via_pkg::VIA_ACK:
            begin
                s_nxt.cnt = 3'(s_r.cnt + 3'h1);
                if (s_r.cnt == ACK_LAST)
                begin
                    s_nxt.pc_load = 1'b1;
                    s_nxt.pc = via_pkg::ACK_VEC;
                    s_nxt.st = via_pkg::VIA_IDLE;
                end
            end
            via_pkg::VIA_DSP_HI:
            begin
                // High byte sits at the even slot address
                s_nxt.mem_rd = 1'b1;
                s_nxt.mem_addr = {s_r.mem_addr[14:1], 1'b1};
                s_nxt.st = via_pkg::VIA_DSP_LO;
            end
            via_pkg::VIA_DSP_LO:
            begin
                s_nxt.vec_hi = mem_data_i[6:0];
                s_nxt.st = via_pkg::VIA_DSP_LOAD;
            end
            via_pkg::VIA_DSP_LOAD:
            begin
                s_nxt.pc_load = 1'b1;
                s_nxt.pc = {s_r.vec_hi, mem_data_i};
                s_nxt.st = via_pkg::VIA_IDLE;
            end
            default:
            begin
                s_nxt.st = via_pkg::VIA_IDLE;
            end
        endcase
        // Trap flag: set wins over a clear in the same cycle
        if (core_i.clr_trap)
            s_nxt.trap = 1'b0;
        if (trap_now)
            s_nxt.trap = 1'b1;
        // Write channel: address and data taken in either order
        if (s_r.bvalid && s_axi_bready_i)
            s_nxt.bvalid = 1'b0;
        if (s_axi_awvalid_i && s_r.awready)
        begin
            s_nxt.aw_have = 1'b1;
            s_nxt.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_r.wready)
        begin
            s_nxt.w_have = 1'b1;
            s_nxt.w_data = s_axi_wdata_i;
            s_nxt.w_strb = s_axi_wstrb_i;
        end
        if (s_r.aw_have && s_r.w_have && !s_r.bvalid)
        begin
            s_nxt.aw_have = 1'b0;
            s_nxt.w_have = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = via_pkg::RESP_OKAY;
            unique case (s_r.aw_addr[7:2])
                via_pkg::REG_CTRL[7:2]:
                begin
                    if (s_r.w_strb[0])
                        s_nxt.en = s_r.w_data[via_pkg::CTRL_EN_LSB
                                              +: via_pkg::SRC_W];
                    // Hardware acknowledge above still overrides; a return only when GIE was clear
                    if (s_r.w_strb[1] && s_nxt.global_interrupt_enable == s_r.global_interrupt_enable)
                        s_nxt.global_interrupt_enable = s_r.w_data[via_pkg::CTRL_GIE_BIT];
                end
                via_pkg::REG_PEND[7:2]:
                begin
                    if (s_r.w_strb[0])
                        s_nxt.pend = s_r.pend
                                     & ~s_r.w_data[via_pkg::SRC_W-1:0];
                end
                via_pkg::REG_STAT[7:2]:
                begin
                    s_nxt.bresp = via_pkg::RESP_OKAY;
                end
                default:
                begin
                    s_nxt.bresp = via_pkg::RESP_SLVERR;
                end
            endcase
        end
        // Source pulses after the clear so a new event is never lost
        s_nxt.pend = s_nxt.pend | src_pulse_i;
        // Read channel; the trap flag is deliberately absent
        if (s_r.rvalid && s_axi_rready_i)
            s_nxt.rvalid = 1'b0;
        if (s_axi_arvalid_i && s_r.arready)
        begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = 32'h0;
            s_nxt.rresp = via_pkg::RESP_OKAY;
            unique case (s_axi_araddr_i[7:2])
                via_pkg::REG_CTRL[7:2]:
                begin
                    s_nxt.rdata[via_pkg::CTRL_EN_LSB +: via_pkg::SRC_W]
                        = s_r.en;
                    s_nxt.rdata[via_pkg::CTRL_GIE_BIT] = s_r.global_interrupt_enable;
                end
                via_pkg::REG_PEND[7:2]:
                begin
                    s_nxt.rdata[via_pkg::SRC_W-1:0] = s_r.pend;
                end
                via_pkg::REG_STAT[7:2]:
                begin
                    s_nxt.rdata[via_pkg::STAT_BUSY_BIT] =
                        s_r.st != via_pkg::VIA_IDLE;
                    s_nxt.rdata[via_pkg::STAT_OFS_LSB +: 8] = s_r.ofs;
                end
                default:
                begin
                    s_nxt.rresp = via_pkg::RESP_SLVERR;
                end
            endcase
        end
        s_nxt.awready = !s_nxt.aw_have && !s_nxt.bvalid;
        s_nxt.wready = !s_nxt.w_have && !s_nxt.bvalid;
        s_nxt.arready = !s_nxt.rvalid;
        s_nxt.busy = s_nxt.st != via_pkg::VIA_IDLE;
    end
    // Single state register; reset clears flag, enables and bus state
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end
    assign s_axi_awready_o = s_r.awready;
    assign s_axi_wready_o = s_r.wready;
    assign s_axi_bvalid_o = s_r.bvalid;
    assign s_axi_bresp_o = s_r.bresp;
    assign s_axi_arready_o = s_r.arready;
    assign s_axi_rvalid_o = s_r.rvalid;
    assign s_axi_rdata_o = s_r.rdata;
    assign s_axi_rresp_o = s_r.rresp;
    assign mem_rd_o = s_r.mem_rd;
    assign mem_addr_o = s_r.mem_addr;
    assign pc_load_o = s_r.pc_load;
    assign pc_o = s_r.pc;
    assign push_o = s_r.push;
    assign push_addr_o = s_r.push_addr;
    assign busy_o = s_r.busy;
    // Checks on dispatch, acknowledge and trap flag behaviour
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    logic vis_go;
    assign vis_go = s_r.st == via_pkg::VIA_IDLE && core_i.vector_dispatch_instruction
                    && !trap_now && !mask_ack;
    trap_offset_a: assert property (
        vis_go && s_r.trap |=> mem_addr_o[7:0] == 8'hFE && mem_rd_o)
        else $error("trap offset wrong");
    ext_offset_a: assert property (
        vis_go && !s_r.trap && act[via_pkg::SRC_EXT]
        |=> mem_addr_o[7:0] == 8'hFA)
        else $error("external offset wrong");
    default_offset_a: assert property (
        vis_go && !s_r.trap && act == '0 |=> mem_addr_o[7:0] == 8'hE0)
        else $error("default offset wrong");
    offset_even_a: assert property (
        s_r.st == via_pkg::VIA_DSP_HI
        |-> !mem_addr_o[0] && mem_addr_o[7:0] >= 8'hE0)
        else $error("offset not even in range");
    table_block_a: assert property (
        vis_go |=> mem_addr_o[14:8] == 7'($past(cur_pc_i[14:8])
                   + ($past(cur_pc_i[7:0]) == 8'hFF)))
        else $error("table block wrong");
    vector_load_a: assert property (
        vis_go |-> ##4 pc_load_o && pc_o[7:0] == $past(mem_data_i)
                   && pc_o[14:8] == $past(mem_data_i[6:0], 2))
        else $error("vector not loaded");
    ack_seven_a: assert property (
        mask_ack |=> push_o && !s_r.global_interrupt_enable ##6 pc_load_o && pc_o == 15'h00FF)
        else $error("acknowledge sequence wrong");
    trap_flag_a: assert property (
        trap_now |=> s_r.trap
                     && ($past(s_r.w_have) || s_r.global_interrupt_enable == $past(s_r.global_interrupt_enable)))
        else $error("trap flag not set");
    trap_clear_a: assert property (
        core_i.clr_trap && !trap_now |=> !s_r.trap)
        else $error("trap flag not cleared");
    trap_push_a: assert property (
        trap_now && s_r.st == via_pkg::VIA_IDLE && core_i.fetch
        |=> push_o && push_addr_o == $past(fetch_addr_i))
        else $error("trap push address wrong");
    trap_block_a: assert property (
        s_r.trap && core_i.instr_start && s_r.st == via_pkg::VIA_IDLE
        && !trap_now |=> !push_o)
        else $error("maskable taken under trap");
    vis_trap_c: cover property (vis_go && s_r.trap);
    mask_ack_c: cover property (mask_ack ##7 core_i.vector_dispatch_instruction);
    nested_trap_c: cover property (trap_now && s_r.trap);
    return_from_interrupt_instruction_c: cover property (s_r.st == via_pkg::VIA_IDLE && core_i.return_from_interrupt_instruction);
endmodule : via_arbiter

// [test/via_mem_model.sv]
// Purpose: Program memory seen by the arbiter's vector fetch
// Assumes: Read data valid for one cycle after the read strobe
// Notes: Content is a fixed pattern of the address; bench mirrors it
`timescale 1ns/10ps
module via_mem_model (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic mem_rd_i,
    input wire logic [14:0] mem_addr_i,
    output logic [7:0] mem_data_o
);
    // Hi byte of a vector at the even slot, lo byte at the odd one
    function automatic logic [7:0] content(input logic [14:0] a);
        content = a[7:0] ^ {1'h0, a[14:8]} ^ 8'hA5;
    endfunction : content

    // Data lasts one cycle; scrambled after so stale reads show up
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            mem_data_o <= 8'h00;
        else if (mem_rd_i)
            mem_data_o <= content(mem_addr_i);
        else
            mem_data_o <= ~mem_data_o;
    end
endmodule : via_mem_model

// [test/via_arbiter_test.sv]
// Purpose: Self-checking bench of the vectored interrupt arbiter
// Assumes: Small memory variant, sequencer strobes one at a time
// Notes: A monitor records when push, load and read strobes appear
`timescale 1ns/10ps
module via_arbiter_test;
    localparam int MEMB = 1024;
    localparam logic [7:0] SLIM = 8'h2F;
    localparam logic [5:0] S_INS = 6'h20, S_DSP = 6'h10, S_CLR = 6'h08;
    localparam logic [5:0] S_RET = 6'h04, S_POP = 6'h02, S_FET = 6'h01;
    logic sys_clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, sp = 8'h00;
    logic [7:0] fetch_data = 8'hFF;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic [5:0] src = 6'h00;
    via_pkg::via_core_t core = '0;
    logic [14:0] cur_pc = 15'h0, next_pc = 15'h0, pop_pc = 15'h0;
    logic [14:0] fetch_addr = 15'h0;
    logic awready, wready, bvalid, arready, rvalid, mem_rd;
    logic pc_load, push, busy, bz;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, d;
    logic [14:0] mem_addr, pc, push_addr, push_a, pcl_v, rd_a;
    logic [7:0] mem_data;
    logic [1:0] r;
    logic [15:0] rnd = 16'hFA3F;
    logic [5:0] en, pend;
    logic [14:0] p;
    int mismatches = 0, check_count = 0, cyc = 0, take_at = 0;
    int push_at = -1, pcl_at = -1, rd_at = -1;

    via_arbiter #(.MEM_BYTES(MEMB), .STACK_LIMIT(SLIM)) DUT (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_awaddr_i(awaddr), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
        .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .src_pulse_i(src), .core_i(core),
        .cur_pc_i(cur_pc), .next_pc_i(next_pc), .pop_pc_i(pop_pc),
        .sp_i(sp), .fetch_addr_i(fetch_addr), .fetch_data_i(fetch_data),
        .mem_data_i(mem_data), .mem_rd_o(mem_rd), .mem_addr_o(mem_addr),
        .pc_load_o(pc_load), .pc_o(pc), .push_o(push),
        .push_addr_o(push_addr), .busy_o(busy));

    via_mem_model mem_model (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .mem_rd_i(mem_rd), .mem_addr_i(mem_addr), .mem_data_o(mem_data));

    // Free-running clock, 4 ns period
    initial
        forever #2 sys_clk_i = ~sys_clk_i;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    // Mirror of the memory content pattern
    function automatic logic [7:0] mem_byte(input logic [14:0] a);
        mem_byte = a[7:0] ^ {1'h0, a[14:8]} ^ 8'hA5;
    endfunction : mem_byte

    // Expected slot offset from trap state and active sources
    function automatic logic [7:0] rank(input logic trap,
                                        input logic [5:0] act);
        logic [7:0] tbl [6] = '{8'hFA, 8'hF8, 8'hF6, 8'hF4, 8'hF2, 8'hE2};
        rank = 8'hE0;
        for (int i = 5; i >= 0; i--)
            if (act[i])
                rank = tbl[i];
        if (trap)
            rank = 8'hFE;
    endfunction : rank

    task complete_run;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run

    task chk(input string nm, input logic [31:0] seen,
             input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Address and data offered together, each released when taken
    task axi_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk_i);
        awvalid <= 1'h1;
        awaddr <= a;
        wvalid <= 1'h1;
        wdata <= v;
        bready <= 1'h1;
        do
        begin
            @(posedge sys_clk_i);
            if (awvalid && awready)
                awvalid <= 1'h0;
            if (wvalid && wready)
                wvalid <= 1'h0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'h0;
    endtask : axi_wr

    task axi_rd(input logic [7:0] a);
        @(posedge sys_clk_i);
        arvalid <= 1'h1;
        araddr <= a;
        rready <= 1'h1;
        do
        begin
            @(posedge sys_clk_i);
            if (arvalid && arready)
                arvalid <= 1'h0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
    endtask : axi_rd

    // One-cycle sequencer strobe, then wait for the sequencer to idle
    task strobe(input logic [5:0] v);
        @(posedge sys_clk_i);
        core <= via_pkg::via_core_t'(v);
        @(posedge sys_clk_i);
        core <= '0;
        // Busy as seen one edge after the strobe was taken
        @(posedge sys_clk_i);
        bz = busy;
        repeat (8) @(posedge sys_clk_i);
        while (busy)
            @(posedge sys_clk_i);
    endtask : strobe

    task disp_chk(input logic [14:0] pa, input logic [7:0] ofs);
        logic [14:0] slot;
        logic [7:0] hi;
        slot = {pa[14:8] + 7'(pa[7:0] == 8'hFF), ofs};
        hi = mem_byte(slot);
        cur_pc <= pa;
        strobe(S_DSP);
        chk("slot address", 32'(rd_a), 32'(slot));
        chk("slot read cycle", rd_at - take_at, 1);
        chk("busy in dispatch", 32'(bz), 32'h1);
        chk("vector", 32'(pcl_v), 32'({hi[6:0], mem_byte(slot | 15'h1)}));
        chk("vector load cycle", pcl_at - take_at, 4);
        axi_rd(via_pkg::REG_STAT);
        chk("last offset", 32'(d[15:8]), 32'(ofs));
    endtask : disp_chk

    task trap_chk(input logic [5:0] v, input logic hit,
                  input logic [14:0] a);
        strobe(v);
        chk("busy", 32'(bz), 32'(hit));
        if (!hit)
            chk("no push", push_at, -1);
        else
        begin
            chk("push cycle", push_at - take_at, 1);
            chk("push address", 32'(push_a), 32'(a));
            chk("jump cycle", pcl_at - take_at, 7);
            chk("jump address", 32'(pcl_v), 32'h00FF);
        end
    endtask : trap_chk

    // Records when each strobe appears after a taken request
    always @(posedge sys_clk_i)
    begin
        if (core != '0)
        begin
            take_at = cyc;
            push_at = -1;
            pcl_at = -1;
            rd_at = -1;
        end
        if (push && push_at < 0)
        begin
            push_at = cyc;
            push_a = push_addr;
        end
        if (pc_load)
        begin
            pcl_at = cyc;
            pcl_v = pc;
        end
        if (mem_rd && rd_at < 0)
        begin
            rd_at = cyc;
            rd_a = mem_addr;
        end
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            complete_run();
        end
    end

    // Main sequence: reset, ranking sweep, trap and acknowledge paths
    initial
    begin
        repeat (8) @(posedge sys_clk_i);
        rst_i <= 1'h0;
        repeat (2) @(posedge sys_clk_i);
        axi_rd(via_pkg::REG_CTRL);
        chk("ctrl reset", d, 32'h0);
        axi_rd(via_pkg::REG_PEND);
        chk("pend reset", d, 32'h0);
        axi_rd(8'h0C);
        chk("unmapped resp", 32'(r), 32'(via_pkg::RESP_SLVERR));
        axi_wr(8'h0C, 32'h3F);
        chk("unmapped wr resp", 32'(r), 32'(via_pkg::RESP_SLVERR));
        disp_chk(15'h0123, 8'hE0);
        // Single sources first, then random mixes with page corners
        for (int i = 0; i < 16; i++)
        begin
            rnd = lfsr(rnd);
            en = (i < 6) ? 6'h3F : rnd[5:0];
            pend = (i < 6) ? 6'(1 << i) : rnd[13:8];
            rnd = lfsr(rnd);
            p = rnd[14:0];
            if (i == 6 || i == 7)
                p[7:0] = 8'hFE + 8'(i - 6);
            axi_wr(via_pkg::REG_CTRL, {26'h0, en});
            chk("write resp", 32'(r), 32'(via_pkg::RESP_OKAY));
            src <= pend;
            @(posedge sys_clk_i);
            src <= 6'h00;
            disp_chk(p, rank(1'h0, en & pend));
            axi_wr(via_pkg::REG_PEND, 32'h3F);
        end
        axi_wr(via_pkg::REG_CTRL, 32'h0000_0101);
        src <= 6'h01;
        @(posedge sys_clk_i);
        src <= 6'h00;
        fetch_addr <= 15'h0234;
        fetch_data <= 8'h00;
        trap_chk(S_FET, 1'h1, 15'h0234);
        axi_rd(via_pkg::REG_CTRL);
        chk("enable kept", 32'(d[8]), 32'h1);
        disp_chk(15'h0300, 8'hFE);
        trap_chk(S_INS, 1'h0, 15'h0);
        fetch_addr <= 15'(MEMB - 1);
        fetch_data <= 8'h5A;
        trap_chk(S_FET, 1'h0, 15'h0);
        fetch_addr <= 15'(MEMB);
        trap_chk(S_FET, 1'h1, 15'(MEMB));
        cur_pc <= 15'h0456;
        sp <= SLIM;
        trap_chk(S_POP, 1'h0, 15'h0);
        sp <= SLIM + 8'h01;
        trap_chk(S_POP, 1'h1, 15'h0456);
        trap_chk(S_CLR, 1'h0, 15'h0);
        disp_chk(15'h0500, 8'hFA);
        trap_chk(S_CLR, 1'h0, 15'h0);
        next_pc <= 15'h0678;
        trap_chk(S_INS, 1'h1, 15'h0678);
        axi_rd(via_pkg::REG_CTRL);
        chk("enable cleared", 32'(d[8]), 32'h0);
        pop_pc <= 15'h1357;
        strobe(S_RET);
        chk("return cycle", pcl_at - take_at, 1);
        chk("return address", 32'(pcl_v), 32'h1357);
        axi_rd(via_pkg::REG_CTRL);
        chk("enable restored", 32'(d[8]), 32'h1);
        complete_run();
    end
endmodule : via_arbiter_test
